/* File: dcl_pkg.sv */
/*
 * dcl_pkg: register map, field positions, reset values and reference codes
 * for the converter control block.
 * Assumes a byte-wide register port with a 9-bit register address.
 */
package dcl_pkg;

	localparam int ADDR_W = 9;
	localparam int DATA_W = 8;

	localparam logic [8:0] CONVERTER_CODE_OFFSET    = 9'h11e;
	localparam logic [8:0] CONVERTER_CONTROL_OFFSET = 9'h11f;

	localparam logic [7:0] CONVERTER_CODE_RESET    = 8'h00;
	localparam logic [7:0] CONVERTER_CONTROL_RESET = 8'h00;

	localparam int CTRL_ENABLE_BIT   = 7;
	localparam int CTRL_PIN_OE_BIT   = 6;
	localparam int CTRL_REFSEL_MSB   = 1;
	localparam int CTRL_REFSEL_LSB   = 0;

	// writable bits of the control register
	localparam logic [7:0] CTRL_WRITE_MASK = 8'hc3;

	typedef enum logic [1:0] {
		DCL_REF_SUPPLY   = 2'h0,
		DCL_REF_CMP_PIN  = 2'h1,
		DCL_REF_INTERNAL = 2'h2,
		DCL_REF_RESERVED = 2'h3
	} dcl_ref_type;

	// one-hot reference mux selects: supply, comparator pin, internal
	localparam logic [2:0] REF_ONEHOT_SUPPLY   = 3'h1;
	localparam logic [2:0] REF_ONEHOT_CMP_PIN  = 3'h2;
	localparam logic [2:0] REF_ONEHOT_INTERNAL = 3'h4;
	localparam logic [2:0] REF_ONEHOT_NONE     = 3'h0;

endpackage : dcl_pkg

/* File: dcl_cfg_if.sv */
/*
 * dcl_cfg_if: carries the stored register contents from the register file
 * to the analog drive stage.
 * Assumes one clock domain shared by both ends.
 */
`timescale 1ns/10ps
interface dcl_cfg_if;
	import dcl_pkg::*;
	logic [7:0] code_q;
	logic [7:0] ctrl_q;
	modport regs  (output code_q, output ctrl_q);
	modport drive (input code_q, input ctrl_q);
endinterface : dcl_cfg_if

/* File: dcl_analog_drive.sv */
/*
 * dcl_analog_drive: turns stored control and code into registered analog
 * controls for the ladder, reference mux and output buffer.
 * Assumes the register file updates its values synchronously on CLK.
 */
`timescale 1ns/10ps
module dcl_analog_drive
	import dcl_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	dcl_cfg_if.drive        cfg,
	output logic            enable_q,
	output logic            pin_oe_q,
	output logic [7:0]      code_q,
	output logic [2:0]      ref_sel_q
);

	function automatic logic [2:0] ref_decode(input logic [1:0] f);
		case (f)
			DCL_REF_SUPPLY:   ref_decode = REF_ONEHOT_SUPPLY;
			DCL_REF_CMP_PIN:  ref_decode = REF_ONEHOT_CMP_PIN;
			DCL_REF_INTERNAL: ref_decode = REF_ONEHOT_INTERNAL;
			default:          ref_decode = REF_ONEHOT_NONE;
		endcase
	endfunction : ref_decode

	logic en_d;
	assign en_d = cfg.ctrl_q[CTRL_ENABLE_BIT];

	always_ff @(posedge clk) begin
		if (rst) begin
			enable_q  <= 1'b0;
			pin_oe_q  <= 1'b0;
			code_q    <= CONVERTER_CODE_RESET;
			ref_sel_q <= REF_ONEHOT_SUPPLY;
		end else begin
			enable_q  <= en_d;
			pin_oe_q  <= en_d & cfg.ctrl_q[CTRL_PIN_OE_BIT];
			code_q    <= cfg.code_q;
			ref_sel_q <= ref_decode(cfg.ctrl_q[CTRL_REFSEL_MSB:CTRL_REFSEL_LSB]);
		end
	end

endmodule : dcl_analog_drive

/* File: dac_control_logic.sv */
/*
 * dac_control_logic: register file and control for an 8-bit converter.
 * Assumes a single-cycle register port on CLK; analog parts sit outside.
 */
// The plain strobed port is this design's own decision.
// Function
// - converter powered only while enable bit set
// - pin output needs pin enable and enable
// - reference field decodes supply, pin, internal, reserved
// - control bits 5-2 read zero, ignore writes
// - code register value drives the converter
// - code register fully readable, writable, resets zero
// - reset clears enable, reference, pin, code
// - output offered to ADC, comparators, pin
`timescale 1ns/10ps
module dac_control_logic
	import dcl_pkg::*;
(
	input  wire logic              CLK,
	input  wire logic              SYS_RST,
	input  wire logic [ADDR_W-1:0] REG_ADDR,
	input  wire logic [DATA_W-1:0] REG_WDATA,
	input  wire logic              REG_WR,
	input  wire logic              REG_RD,
	output logic      [DATA_W-1:0] REG_RDATA,
	output logic                   CONVERTER_ENABLE,
	output logic                   ANALOG_OUTPUT_PIN_EN,
	output logic                   INTERNAL_REF_AVAIL,
	output logic      [7:0]        CONVERSION_CODE,
	output logic      [2:0]        REFERENCE_SELECT
);

	////////////////////////////////////////////////////////////////////////
	dcl_cfg_if cfg ();

	logic [7:0] code_q;
	logic [7:0] ctrl_q;
	logic [7:0] rdata_q;
	logic       avail_q;

	assign cfg.code_q = code_q;
	assign cfg.ctrl_q = ctrl_q;

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			code_q <= CONVERTER_CODE_RESET;
		end else if (REG_WR && REG_ADDR == CONVERTER_CODE_OFFSET) begin
			code_q <= REG_WDATA;
		end
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			ctrl_q <= CONVERTER_CONTROL_RESET;
		end else if (REG_WR && REG_ADDR == CONVERTER_CONTROL_OFFSET) begin
			ctrl_q <= REG_WDATA & CTRL_WRITE_MASK;
		end
	end

	// read data valid only in the cycle after the strobe; unmapped reads zero
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			rdata_q <= 8'h00;
		end else if (REG_RD && REG_ADDR == CONVERTER_CODE_OFFSET) begin
			rdata_q <= code_q;
		end else if (REG_RD && REG_ADDR == CONVERTER_CONTROL_OFFSET) begin
			rdata_q <= ctrl_q & CTRL_WRITE_MASK;
		end else begin
			rdata_q <= 8'h00;
		end
	end
	assign REG_RDATA = rdata_q;

	// output offered internally to ADC and comparators whenever enabled
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			avail_q <= 1'b0;
		end else begin
			avail_q <= ctrl_q[CTRL_ENABLE_BIT];
		end
	end
	assign INTERNAL_REF_AVAIL = avail_q;

	////////////////////////////////////////////////////////////////////////
	dcl_analog_drive u_drive (
		.clk       (CLK),
		.rst       (SYS_RST),
		.cfg       (cfg),
		.enable_q  (CONVERTER_ENABLE),
		.pin_oe_q  (ANALOG_OUTPUT_PIN_EN),
		.code_q    (CONVERSION_CODE),
		.ref_sel_q (REFERENCE_SELECT)
	);

	////////////////////////////////////////////////////////////////////////
	sequence ctrl_write_s;
		REG_WR && REG_ADDR == CONVERTER_CONTROL_OFFSET;
	endsequence

	sequence code_write_s;
		REG_WR && REG_ADDR == CONVERTER_CODE_OFFSET;
	endsequence

	sequence code_read_s;
		REG_RD && REG_ADDR == CONVERTER_CODE_OFFSET;
	endsequence

	sequence ctrl_read_s;
		REG_RD && REG_ADDR == CONVERTER_CONTROL_OFFSET;
	endsequence

	// a write that hits neither register must leave both untouched
	sequence stray_write_s;
		REG_WR && REG_ADDR != CONVERTER_CODE_OFFSET
		&& REG_ADDR != CONVERTER_CONTROL_OFFSET;
	endsequence

	enable_follow_a: assert property (@(posedge CLK) disable iff (SYS_RST)
		ctrl_write_s |-> ##2 CONVERTER_ENABLE == $past(REG_WDATA[CTRL_ENABLE_BIT], 2))
		else $error("enable does not follow control write");

	pin_gate_a: assert property (@(posedge CLK) disable iff (SYS_RST)
		ANALOG_OUTPUT_PIN_EN |-> $past(ctrl_q[CTRL_PIN_OE_BIT] && ctrl_q[CTRL_ENABLE_BIT]))
		else $error("pin output without both enables");

	ref_decode_a: assert property (@(posedge CLK) disable iff (SYS_RST)
		ctrl_write_s ##1 !REG_WR |-> ##1 REFERENCE_SELECT ==
		(($past(REG_WDATA[1:0], 2) == 2'h0) ? REF_ONEHOT_SUPPLY :
		 ($past(REG_WDATA[1:0], 2) == 2'h1) ? REF_ONEHOT_CMP_PIN :
		 ($past(REG_WDATA[1:0], 2) == 2'h2) ? REF_ONEHOT_INTERNAL : REF_ONEHOT_NONE))
		else $error("reference select decode wrong");

	unused_zero_a: assert property (@(posedge CLK) disable iff (SYS_RST)
		REG_RD && REG_ADDR == CONVERTER_CONTROL_OFFSET |=> REG_RDATA[5:2] == 4'h0)
		else $error("unused control bits read nonzero");

	code_drive_a: assert property (@(posedge CLK) disable iff (SYS_RST)
		code_write_s ##1 !REG_WR |-> ##1 CONVERSION_CODE == $past(REG_WDATA, 2))
		else $error("code not presented to converter");

	code_readback_a: assert property (@(posedge CLK) disable iff (SYS_RST)
		code_write_s ##1 (REG_RD && REG_ADDR == CONVERTER_CODE_OFFSET)
		|=> REG_RDATA == $past(REG_WDATA, 2))
		else $error("code readback mismatch");

	reset_state_a: assert property (@(posedge CLK)
		SYS_RST |=> !CONVERTER_ENABLE && !ANALOG_OUTPUT_PIN_EN && !INTERNAL_REF_AVAIL
		&& CONVERSION_CODE == 8'h00 && REFERENCE_SELECT == REF_ONEHOT_SUPPLY)
		else $error("reset state wrong");

	avail_track_a: assert property (@(posedge CLK) disable iff (SYS_RST)
		INTERNAL_REF_AVAIL == CONVERTER_ENABLE)
		else $error("internal availability differs from enable");

	off_quiet_a: assert property (@(posedge CLK) disable iff (SYS_RST)
		!CONVERTER_ENABLE |-> !ANALOG_OUTPUT_PIN_EN)
		else $error("pin enabled while converter off");

	////////////////////////////////////////////////////////////////////////
	// read port: data stands one cycle after the strobe, zero otherwise
	ctrl_readback_a: assert property (@(posedge CLK) disable iff (SYS_RST)
		ctrl_write_s ##1 ctrl_read_s
		|=> REG_RDATA == ($past(REG_WDATA, 2) & CTRL_WRITE_MASK))
		else $error("control readback mismatch");

	code_reads_a: assert property (@(posedge CLK) disable iff (SYS_RST)
		code_read_s |=> REG_RDATA == $past(code_q))
		else $error("code read returns wrong value");

	ctrl_reads_a: assert property (@(posedge CLK) disable iff (SYS_RST)
		ctrl_read_s |=> REG_RDATA == $past(ctrl_q))
		else $error("control read returns wrong value");

	rdata_idle_a: assert property (@(posedge CLK) disable iff (SYS_RST)
		!REG_RD |=> REG_RDATA == 8'h00)
		else $error("read data not zero outside read");

	stray_read_a: assert property (@(posedge CLK) disable iff (SYS_RST)
		REG_RD && REG_ADDR != CONVERTER_CODE_OFFSET
		&& REG_ADDR != CONVERTER_CONTROL_OFFSET |=> REG_RDATA == 8'h00)
		else $error("unmapped read returns nonzero");

	// register contents
	stray_ignore_a: assert property (@(posedge CLK) disable iff (SYS_RST)
		stray_write_s |=> $stable(code_q) && $stable(ctrl_q))
		else $error("unmapped write changed a register");

	reg_hold_a: assert property (@(posedge CLK) disable iff (SYS_RST)
		!REG_WR |=> $stable(code_q) && $stable(ctrl_q))
		else $error("register changed without a write");

	reg_reset_a: assert property (@(posedge CLK)
		SYS_RST |=> code_q == CONVERTER_CODE_RESET
		&& ctrl_q == CONVERTER_CONTROL_RESET)
		else $error("registers not at reset value");

	// analog controls
	ref_reserved_a: assert property (@(posedge CLK) disable iff (SYS_RST)
		ctrl_q[CTRL_REFSEL_MSB:CTRL_REFSEL_LSB] == DCL_REF_RESERVED
		|=> REFERENCE_SELECT == REF_ONEHOT_NONE)
		else $error("reserved reference code selects a reference");

	ref_onehot_a: assert property (@(posedge CLK) disable iff (SYS_RST)
		$onehot0(REFERENCE_SELECT))
		else $error("more than one reference selected");

	pin_follow_a: assert property (@(posedge CLK) disable iff (SYS_RST)
		ctrl_write_s ##1 !REG_WR |-> ##1 ANALOG_OUTPUT_PIN_EN ==
		($past(REG_WDATA[CTRL_PIN_OE_BIT], 2) && $past(REG_WDATA[CTRL_ENABLE_BIT], 2)))
		else $error("pin enable does not follow control write");

	enable_only_a: assert property (@(posedge CLK) disable iff (SYS_RST)
		CONVERTER_ENABLE |-> $past(ctrl_q[CTRL_ENABLE_BIT]))
		else $error("converter powered with enable bit clear");

	enable_off_a: assert property (@(posedge CLK) disable iff (SYS_RST)
		!ctrl_q[CTRL_ENABLE_BIT] |=> !CONVERTER_ENABLE
		&& !ANALOG_OUTPUT_PIN_EN && !INTERNAL_REF_AVAIL)
		else $error("analog controls active while disabled");

	code_follow_a: assert property (@(posedge CLK) disable iff (SYS_RST)
		$past(!SYS_RST) |-> CONVERSION_CODE == $past(code_q))
		else $error("converter code differs from code register");

	avail_follow_a: assert property (@(posedge CLK) disable iff (SYS_RST)
		$past(!SYS_RST) |-> INTERNAL_REF_AVAIL == $past(ctrl_q[CTRL_ENABLE_BIT]))
		else $error("internal availability differs from enable bit");

endmodule : dac_control_logic

/* File: dcl_ladder_model.sv */
/*
 * dcl_ladder_model: behavioural ladder and pin buffer.
 * Assumes the registered analog controls of dac_control_logic.
 */
`timescale 1ns/10ps
module dcl_ladder_model (
	input  wire logic       en,
	input  wire logic       oe,
	input  wire logic [7:0] code,
	output logic      [7:0] pin_lvl
);
	// pin level follows the code only while routed out; consumers pick it themselves
	assign pin_lvl = (en && oe) ? code : 8'h00;
endmodule : dcl_ladder_model

/* File: test_dac_control_logic.sv */
/*
 * test_dac_control_logic: register and analog control checks.
 * Assumes a single-cycle register port and the ladder model alongside.
 */
`timescale 1ns/10ps
module test_dac_control_logic;
	import dcl_pkg::*;
	logic       clk = 0, rst = 1, wr = 0, rd = 0, en, oe, iref;
	logic [8:0] addr = '0;
	logic [7:0] wd = '0, rdat, code, lvl;
	logic [2:0] rs;
	int         error_cnt = 0, total_checks = 0;
	logic [2:0] oh [4] = '{REF_ONEHOT_SUPPLY, REF_ONEHOT_CMP_PIN, REF_ONEHOT_INTERNAL,
		REF_ONEHOT_NONE};
	always #5 clk = ~clk;
	dac_control_logic i_dut (.CLK(clk), .SYS_RST(rst), .REG_ADDR(addr), .REG_WDATA(wd),
		.REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdat), .CONVERTER_ENABLE(en),
		.ANALOG_OUTPUT_PIN_EN(oe), .INTERNAL_REF_AVAIL(iref), .CONVERSION_CODE(code),
		.REFERENCE_SELECT(rs));
	dcl_ladder_model i_ladder (.en(en), .oe(oe), .code(code), .pin_lvl(lvl));
	////////////////////////////////////////////////////////////////////////
	task chk(string n, logic [7:0] e, logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task wr_reg(logic [8:0] a, logic [7:0] d);
		@(posedge clk);
		wr <= 1;
		addr <= a;
		wd <= d;
		@(posedge clk);
		wr <= 0;
	endtask : wr_reg
	task rd_reg(logic [8:0] a, logic [7:0] e);
		@(posedge clk);
		rd <= 1;
		addr <= a;
		@(posedge clk);
		rd <= 0;
		#1;
		chk("read data", e, rdat);
	endtask : rd_reg
	task wr_rd(logic [8:0] a, logic [7:0] d, logic [7:0] e);
		@(posedge clk);
		wr <= 1;
		addr <= a;
		wd <= d;
		@(posedge clk);
		wr <= 0;
		rd <= 1;
		@(posedge clk);
		rd <= 0;
		#1;
		chk("read back", e, rdat);
	endtask : wr_rd
	task outs(logic e, logic p, logic [7:0] c, logic [2:0] r);
		@(posedge clk);
		#1;
		chk("enable", e, en);
		chk("pin enable", p, oe);
		chk("internal ref", e, iref);
		chk("code", c, code);
		chk("reference", r, rs);
		chk("pin level", p ? c : 8'h00, lvl);
	endtask : outs
	task conclude;
		if (error_cnt == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : conclude
	////////////////////////////////////////////////////////////////////////
	initial begin
		#100000;
		error_cnt++;
		conclude();
	end
	initial begin
		repeat (5) @(posedge clk);
		rst <= 0;
		outs(0, 0, 8'h00, REF_ONEHOT_SUPPLY);
		rd_reg(CONVERTER_CODE_OFFSET, CONVERTER_CODE_RESET);
		rd_reg(CONVERTER_CONTROL_OFFSET, CONVERTER_CONTROL_RESET);
		wr_reg(CONVERTER_CODE_OFFSET, 8'ha5);
		outs(0, 0, 8'ha5, REF_ONEHOT_SUPPLY);
		rd_reg(CONVERTER_CODE_OFFSET, 8'ha5);
		for (int i = 0; i < 4; i++) begin
			wr_reg(CONVERTER_CONTROL_OFFSET, 8'hfc | i[7:0]);
			outs(1, 1, 8'ha5, oh[i]);
			rd_reg(CONVERTER_CONTROL_OFFSET, 8'hc0 | i[7:0]);
		end
		wr_reg(CONVERTER_CONTROL_OFFSET, 8'h41);
		outs(0, 0, 8'ha5, REF_ONEHOT_CMP_PIN);
		wr_reg(CONVERTER_CONTROL_OFFSET, 8'h80);
		outs(1, 0, 8'ha5, REF_ONEHOT_SUPPLY);
		wr_reg(9'h11d, 8'hff);
		rd_reg(9'h11d, 8'h00);
		rd_reg(CONVERTER_CODE_OFFSET, 8'ha5);
		wr_reg(CONVERTER_CONTROL_OFFSET, 8'hc2);
		outs(1, 1, 8'ha5, REF_ONEHOT_INTERNAL);
		@(posedge clk);
		rst <= 1;
		@(posedge clk);
		rst <= 0;
		outs(0, 0, 8'h00, REF_ONEHOT_SUPPLY);
		rd_reg(CONVERTER_CONTROL_OFFSET, 8'h00);
		wr_rd(CONVERTER_CODE_OFFSET, 8'h3c, 8'h3c);
		wr_rd(CONVERTER_CONTROL_OFFSET, 8'h7f, 8'h43);
		outs(0, 0, 8'h3c, REF_ONEHOT_NONE);
		conclude();
	end
endmodule : test_dac_control_logic
